/* File: logic/hvcfg_defines.svh */
// constants for the high-voltage indirect configuration registers
`ifndef HVCFG_DEFINES_SVH
`define HVCFG_DEFINES_SVH
`define HVCFG_CMD_RD_A      8'h00
`define HVCFG_CMD_RD_B      8'h01
`define HVCFG_CMD_WR_A      8'h08
`define HVCFG_CMD_WR_B      8'h09
`define HVCFG_RESET_VAL     8'h00
`define HVCFG_BIT_THERM_DIS 7
`define HVCFG_BIT_OSC_EN    6
`define HVCFG_BIT_BITSERIAL 5
`define HVCFG_BIT_WAKE      4
`define HVCFG_BIT_SUPMON    3
`define HVCFG_BIT_LVF       2
`define HVCFG_LIN_HI        1
`define HVCFG_LIN_LO        0
`define HVCFG_ST_BUSY       0
`define HVCFG_ST_RD_OK      1
`define HVCFG_ST_WR_OK      2
`define HVCFG_OSC_START_US  70
`define HVCFG_CLK_MHZ       125
`define HVCFG_LATENCY_CYC   4
`endif

/* File: logic/hvcfg_pkg.sv */
// types for the high-voltage indirect configuration registers
package hvcfg_pkg;
  typedef enum logic [1:0] {
    HVCFG_LIN_OFF  = 2'h0,
    HVCFG_LIN_RSVD = 2'h1,
    HVCFG_LIN_ON   = 2'h2,
    HVCFG_LIN_FAST = 2'h3
  } hvcfg_lin_t;
  typedef struct packed {
    logic       therm_shut_dis;
    logic       osc_en;
    logic       bitserial_mode;
    logic       wake_high;
    logic       supply_mon_en;
    logic       low_volt_flag_en;
    hvcfg_lin_t lin_mode;
  } hvcfg_ctrl_a_t;
  typedef struct packed {
    logic       busy;
    logic       rd_ok;
    logic       wr_ok;
  } hvcfg_status_t;
  typedef enum logic [2:0] {
    HVCFG_IDLE = 3'h1,
    HVCFG_WAIT = 3'h2,
    HVCFG_DONE = 3'h4
  } hvcfg_state_t;
endpackage : hvcfg_pkg

/* File: logic/hvcfg_regfile.sv */
// storage of the two indirect configuration registers
`timescale 1ns/100ps
`include "hvcfg_defines.svh"
module hvcfg_regfile
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       we_i,
  input  wire logic       addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic      [7:0] reg_a_o
);
  logic [7:0] mem_q [2];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mem_q[0] <= `HVCFG_RESET_VAL;
      mem_q[1] <= `HVCFG_RESET_VAL;
    end
    else if (we_i)
    begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 8'h00;
    end
    else
    begin
      rdata_o <= mem_q[addr_i];
    end
  end

  assign reg_a_o = mem_q[0];
endmodule : hvcfg_regfile

/* File: logic/hvcfg_top.sv */
// high-voltage indirect configuration register bank with command port
//
// Notes on behaviour
// - two 8-bit read/write registers, reset zero
// - reached only via command and data ports
// - bit7 one disables wake driver thermal shutdown
// - bit6 enables precision oscillator, 70us startup
// - bit5 selects pull-up or bitserial pin mode
// - bit4 drives wake pin high, else pulldown
// - bit3 enables supply monitor, gated interrupt
// - bit2 enables low-voltage flag reporting
// - bits1-0 select LIN driver mode
// - commands 00/01 read registers into data
// - commands 08/09 write data into registers
`timescale 1ns/100ps
`include "hvcfg_defines.svh"
module hvcfg_top
#(
  parameter int LATENCY_CYC = `HVCFG_LATENCY_CYC,
  parameter int OSC_START_US = `HVCFG_OSC_START_US
)
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 cmd_we_i,
  input  wire logic [7:0]           cmd_wdata_i,
  output hvcfg_pkg::hvcfg_status_t  cmd_status_o,
  input  wire logic                 dat_we_i,
  input  wire logic [7:0]           dat_wdata_i,
  output logic      [11:0]          dat_rdata_o,
  output hvcfg_pkg::hvcfg_ctrl_a_t  ctrl_a_o,
  output logic                      wake_drv_o,
  output logic                      wake_pulldown_o,
  output logic                      osc_ready_o,
  input  wire logic                 thermal_event_i,
  input  wire logic                 supply_low_i,
  input  wire logic                 supply_irq_en_i,
  output logic                      supply_irq_o
);
  import hvcfg_pkg::*;

  localparam int OSC_CYC = OSC_START_US * `HVCFG_CLK_MHZ;

  // refuse settings the 8-bit wait and 16-bit oscillator counters cannot hold
  if (LATENCY_CYC < 1 || LATENCY_CYC > 255)
  begin : g_bad_latency
    $error("LATENCY_CYC out of range");
  end
  if (OSC_CYC < 1 || OSC_CYC > 65535)
  begin : g_bad_osc
    $error("OSC_START_US out of range");
  end

  // ***************************************************
  // command decode
  // ***************************************************
  function automatic logic cmd_valid(input logic [7:0] c);
    cmd_valid = (c == `HVCFG_CMD_RD_A) || (c == `HVCFG_CMD_RD_B) ||
                (c == `HVCFG_CMD_WR_A) || (c == `HVCFG_CMD_WR_B);
  endfunction : cmd_valid

  function automatic logic cmd_is_wr(input logic [7:0] c);
    cmd_is_wr = c[3];
  endfunction : cmd_is_wr

  // ***************************************************
  // synchronisers for analogue inputs
  // ***************************************************
  logic [1:0] therm_s_q;
  logic [1:0] low_s_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      therm_s_q <= 2'h0;
      low_s_q   <= 2'h0;
    end
    else
    begin
      therm_s_q <= {therm_s_q[0], thermal_event_i};
      low_s_q   <= {low_s_q[0], supply_low_i};
    end
  end

  // ***************************************************
  // command sequencer
  // ***************************************************
  hvcfg_state_t state_q;
  logic [7:0]   cmd_q;
  logic [7:0]   data_q;
  logic [7:0]   wait_q;
  logic         rf_we;
  logic [7:0]   rf_rdata;
  logic [7:0]   reg_a;

  // a command written while busy is ignored
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= HVCFG_IDLE;
      cmd_q   <= 8'h00;
      wait_q  <= 8'h00;
    end
    else
    begin
      case (state_q)
        HVCFG_IDLE:
        begin
          if (cmd_we_i)
          begin
            cmd_q   <= cmd_wdata_i;
            wait_q  <= 8'(LATENCY_CYC - 1);
            state_q <= HVCFG_WAIT;
          end
        end
        HVCFG_WAIT:
        begin
          if (wait_q == 8'h00)
            state_q <= HVCFG_DONE;
          else
            wait_q <= wait_q - 8'h01;
        end
        HVCFG_DONE:
        begin
          state_q <= HVCFG_IDLE;
        end
        default:
        begin
          state_q <= HVCFG_IDLE;
        end
      endcase
    end
  end

  assign rf_we = (state_q == HVCFG_WAIT) && (wait_q == 8'h00) &&
                 cmd_valid(cmd_q) && cmd_is_wr(cmd_q);

  hvcfg_regfile hvcfg_regfile_i
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (rf_we),
    .addr_i  (cmd_q[0]),
    .wdata_i (data_q),
    .rdata_o (rf_rdata),
    .reg_a_o (reg_a)
  );

  // ***************************************************
  // data port and status
  // ***************************************************
  logic [3:0] tag_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_q <= 8'h00;
      tag_q  <= 4'h0;
    end
    else if (state_q == HVCFG_DONE && cmd_valid(cmd_q))
    begin
      tag_q <= cmd_q[3:0];
      if (!cmd_is_wr(cmd_q))
        data_q <= rf_rdata;
    end
    else if (dat_we_i && state_q == HVCFG_IDLE)
    begin
      data_q <= dat_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_status_o <= '0;
      dat_rdata_o  <= 12'h000;
    end
    else
    begin
      cmd_status_o.busy <= (state_q != HVCFG_IDLE) || cmd_we_i;
      if (state_q == HVCFG_DONE)
      begin
        cmd_status_o.rd_ok <= cmd_valid(cmd_q) && !cmd_is_wr(cmd_q);
        cmd_status_o.wr_ok <= cmd_valid(cmd_q) && cmd_is_wr(cmd_q);
      end
      dat_rdata_o <= {tag_q, data_q};
    end
  end

  // ***************************************************
  // high-voltage controls from register a
  // ***************************************************
  hvcfg_ctrl_a_t ctrl_a;
  logic [15:0]   osc_cnt_q;

  assign ctrl_a = hvcfg_ctrl_a_t'(reg_a);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_a_o        <= '0;
      wake_drv_o      <= 1'b0;
      wake_pulldown_o <= 1'b1;
      supply_irq_o    <= 1'b0;
    end
    else
    begin
      ctrl_a_o <= ctrl_a;
      wake_drv_o <= ctrl_a.wake_high &&
                    (ctrl_a.therm_shut_dis || !therm_s_q[1]);
      wake_pulldown_o <= !ctrl_a.wake_high;
      supply_irq_o <= ctrl_a.supply_mon_en && supply_irq_en_i && low_s_q[1];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      osc_cnt_q   <= 16'h0000;
      osc_ready_o <= 1'b0;
    end
    else if (!ctrl_a.osc_en)
    begin
      osc_cnt_q   <= 16'h0000;
      osc_ready_o <= 1'b0;
    end
    else if (osc_cnt_q != 16'(OSC_CYC))
    begin
      osc_cnt_q <= osc_cnt_q + 16'h0001;
    end
    else
    begin
      osc_ready_o <= 1'b1;
    end
  end
endmodule : hvcfg_top

/* File: sim/hvcfg_props.sv */
// assertions on the ports of the indirect config bank
`timescale 1ns/100ps
module hvcfg_props
(
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cmd_we_i,
  input hvcfg_pkg::hvcfg_status_t cmd_status_o,
  input hvcfg_pkg::hvcfg_ctrl_a_t ctrl_a_o,
  input wire logic                wake_drv_o,
  input wire logic                wake_pulldown_o,
  input wire logic                osc_ready_o,
  input wire logic                thermal_event_i,
  input wire logic                supply_irq_en_i,
  input wire logic                supply_irq_o
);
  import hvcfg_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // busy holds for latency plus two, then drops
  sequence busy_run;
    cmd_status_o.busy[*6] ##1 !cmd_status_o.busy;
  endsequence
  busy_cause_a: assert property ($rose(cmd_status_o.busy) |-> $past(cmd_we_i))
    else $error("busy rose without a command");
  busy_len_a: assert property ($rose(cmd_status_o.busy) |-> busy_run)
    else $error("busy length wrong");
  stat_hold_a: assert property (!cmd_status_o.busy && !cmd_we_i |=> $stable(cmd_status_o))
    else $error("status moved while idle");
  wake_excl_a: assert property (wake_drv_o |-> !wake_pulldown_o)
    else $error("wake driven and pulled down");
  wake_low_a: assert property (!ctrl_a_o.wake_high [*2] |-> !wake_drv_o)
    else $error("wake driven with bit clear");
  therm_shut_a: assert property ((thermal_event_i && !ctrl_a_o.therm_shut_dis) [*5] |-> !wake_drv_o)
    else $error("wake not shut down on thermal event");
  osc_gate_a: assert property (osc_ready_o |-> ctrl_a_o.osc_en || $past(ctrl_a_o.osc_en))
    else $error("oscillator ready while off");
  irq_gate_a: assert property (supply_irq_o |-> $past(supply_irq_en_i)
    && (ctrl_a_o.supply_mon_en || $past(ctrl_a_o.supply_mon_en)))
    else $error("supply interrupt not gated");
endmodule : hvcfg_props
bind hvcfg_top hvcfg_props hvcfg_props_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_we_i(cmd_we_i),
  .cmd_status_o(cmd_status_o), .ctrl_a_o(ctrl_a_o), .wake_drv_o(wake_drv_o),
  .wake_pulldown_o(wake_pulldown_o), .osc_ready_o(osc_ready_o),
  .thermal_event_i(thermal_event_i), .supply_irq_en_i(supply_irq_en_i),
  .supply_irq_o(supply_irq_o));

/* File: sim/hvcfg_sw_model.sv */
// software side: writes the data port and issues commands
`timescale 1ns/100ps
module hvcfg_sw_model
(
  input wire logic                clk_i,
  input hvcfg_pkg::hvcfg_status_t st_i,
  output logic                    cmd_we_o,
  output logic [7:0]              cmd_o,
  output logic                    dat_we_o,
  output logic [7:0]              dat_o
);
  import hvcfg_pkg::*;
  initial
  begin
    cmd_we_o = 1'b0;
    dat_we_o = 1'b0;
    cmd_o = 8'hFF;
    dat_o = 8'hFF;
  end
  // released bytes show the inverse, never the old value
  task automatic put(input logic [7:0] d);
    @(posedge clk_i) {dat_we_o, dat_o} <= {1'b1, d};
    @(posedge clk_i) {dat_we_o, dat_o} <= {1'b0, ~d};
  endtask : put
  task automatic cmd(input logic [7:0] c);
    repeat (20) if (st_i.busy) @(posedge clk_i);
    @(posedge clk_i) {cmd_we_o, cmd_o} <= {1'b1, c};
    @(posedge clk_i) {cmd_we_o, cmd_o} <= {1'b0, ~c};
    repeat (2) @(posedge clk_i);
    repeat (20) if (st_i.busy) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask : cmd
endmodule : hvcfg_sw_model

/* File: sim/hv_indirect_config_regs_tb.sv */
// self-checking bench for the indirect config bank
`timescale 1ns/100ps
module hv_indirect_config_regs_tb;
  import hvcfg_pkg::*;
  logic          clk_i, rst_i, cmd_we, dat_we, therm, slow, irq_en, wd, wp, ordy, irq;
  logic [7:0]    cmd_d, dat_d;
  logic [11:0]   rd;
  hvcfg_status_t st;
  hvcfg_ctrl_a_t ca;
  int            num_errors, total_checks, cyc;
  hvcfg_top #(.OSC_START_US(1)) hvcfg_top_i (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_we_i(cmd_we), .cmd_wdata_i(cmd_d), .cmd_status_o(st), .dat_we_i(dat_we),
    .dat_wdata_i(dat_d), .dat_rdata_o(rd), .ctrl_a_o(ca), .wake_drv_o(wd),
    .wake_pulldown_o(wp), .osc_ready_o(ordy), .thermal_event_i(therm),
    .supply_low_i(slow), .supply_irq_en_i(irq_en), .supply_irq_o(irq));
  hvcfg_sw_model hvcfg_sw_model_i (.clk_i(clk_i), .st_i(st), .cmd_we_o(cmd_we),
    .cmd_o(cmd_d), .dat_we_o(dat_we), .dat_o(dat_d));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ****
  // helpers
  // ****
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic b, input logic [7:0] v);
    hvcfg_sw_model_i.put(v);
    hvcfg_sw_model_i.cmd({7'h04, b});
    chk("wr status", 12'h001, {9'h0, st});
  endtask : wr
  task automatic rdc(input logic b, input logic [7:0] e);
    hvcfg_sw_model_i.cmd({7'h00, b});
    chk("rd status", 12'h002, {9'h0, st});
    chk("rd data", {3'h0, b, e}, rd);
  endtask : rdc
  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      results();
    end
  end
  // ****
  // scenarios
  // ****
  task automatic t_rw;
    chk("pulldown", 12'h001, {11'h0, wp});
    rdc(1'b0, 8'h00);
    rdc(1'b1, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(1'b0, 8'h24 | 8'(i));
      chk("ctrl a", {4'h0, 8'h24 | 8'(i)}, {4'h0, ca});
      rdc(1'b0, 8'h24 | 8'(i));
    end
    wr(1'b1, 8'hC3);
    rdc(1'b1, 8'hC3);
    chk("a kept", 12'h027, {4'h0, ca});
    hvcfg_sw_model_i.cmd(8'h05);
    chk("bad status", 12'h000, {9'h0, st});
    chk("bad data", 12'h1C3, rd);
  endtask : t_rw
  task automatic t_pins;
    wr(1'b0, 8'h10);
    chk("wake on", 12'h002, {10'h0, wd, wp});
    @(posedge clk_i) therm <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("wake shut", 12'h000, {10'h0, wd, wp});
    wr(1'b0, 8'h90);
    chk("wake kept", 12'h002, {10'h0, wd, wp});
    @(posedge clk_i) therm <= 1'b0;
    wr(1'b0, 8'h40);
    repeat (100) @(posedge clk_i);
    chk("osc early", 12'h000, {11'h0, ordy});
    repeat (40) @(posedge clk_i);
    chk("osc ready", 12'h001, {11'h0, ordy});
    wr(1'b0, 8'h08);
    @(posedge clk_i) {slow, irq_en} <= 2'b11;
    repeat (5) @(posedge clk_i);
    chk("irq on", 12'h001, {11'h0, irq});
    @(posedge clk_i) irq_en <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("irq masked", 12'h000, {11'h0, irq});
    wr(1'b0, 8'h00);
    chk("wake off", 12'h001, {10'h0, wd, wp});
    @(posedge clk_i) irq_en <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("irq monitor off", 12'h000, {11'h0, irq});
  endtask : t_pins
  // reset in mid-run must clear written registers and outputs, and set the wake pulldown
  task automatic t_reset;
    wr(1'b1, 8'h5A);
    wr(1'b0, 8'h9F);
    chk("pre reset irq", 12'h001, {11'h0, irq});
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset ctrl a", 12'h000, {4'h0, ca});
    chk("reset pins", 12'h001, {10'h0, wd, wp});
    chk("reset status", 12'h000, {9'h0, st});
    chk("reset data", 12'h000, rd);
    chk("reset irq", 12'h000, {11'h0, irq});
    rdc(1'b0, 8'h00);
    rdc(1'b1, 8'h00);
  endtask : t_reset
  initial
  begin
    {rst_i, therm, slow, irq_en} = 4'h8;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rw();
    t_pins();
    t_reset();
    results();
  end
endmodule : hv_indirect_config_regs_tb
